// file: hdl/sif_filter.sv
// Purpose: per-frame admission decision: unknown-frame filters, self filter, port auth, rule table
// Assumes: one frame descriptor per cycle from the lookup engine, same clock
// Notes:   decision is registered, one cycle after the descriptor
`timescale 1ns/10ps
module sif_filter (
  // clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // register bus
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [9:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // frame descriptor from lookup engine
  input  wire logic        frmValid,
  input  wire logic [2:0]  frmSrcPort,
  input  wire logic [47:0] frmDstMac,
  input  wire logic [47:0] frmSrcMac,
  input  wire logic [15:0] frmEthType,
  input  wire logic [31:0] frmIpSrc,
  input  wire logic [31:0] frmIpDst,
  input  wire logic [7:0]  frmIpProto,
  input  wire logic [15:0] frmL4Src,
  input  wire logic [15:0] frmL4Dst,
  input  wire logic [4:0]  frmLookupMap,
  input  wire logic        frmUniMiss,
  input  wire logic        frmMcMiss,
  input  wire logic        frmVidMiss,
  input  wire logic        frmIpMcMiss,
  // decision
  output logic             decValid,
  output logic [4:0]       decMap,
  output logic             decAuth,
  output logic             decAclHit,
  output logic [3:0]       decRule
);
  sif_pkg::sif_state_t st;
  sif_pkg::sif_state_t nx;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic [32:0] rdRes;
  logic [32:0] wrOld;
  logic [31:0] wm;
  logic [7:0]  wi;
  logic [2:0]  pIdx;
  logic [4:0]  srcBit;
  logic [1:0]  authMode;
  logic        aclOn;
  logic [15:0] ruleHit;
  logic        aclHit;
  logic [3:0]  best;
  logic [4:0]  aclMap;
  logic [4:0]  baseMap;
  logic [4:0]  map;
  logic        authHit;
  logic        selfHit;
  logic [31:0] w0;
  logic [31:0] w1;
  logic [31:0] w2;
  logic [31:0] w3;
  logic [47:0] macK;
  logic [31:0] ipK;
  logic [15:0] l4K;
  logic        cmp;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [4:0] portBit(input logic [2:0] p);
    return 5'h01 << p;
  endfunction

  // bit 32 flags a mapped index; narrow registers read zero above their width
  function automatic logic [32:0] regRd(input sif_pkg::sif_state_t s, input logic [7:0] i);
    logic [32:0] r;
    r = {1'b1, sif_pkg::WORD_RST};
    if (i[7:6] == sif_pkg::TBL_SEL) begin
      r[31:0] = s.tbl[i[5:0]];
    end else if (i == sif_pkg::IDX_GC15) begin
      r[7:0] = s.gcUni;
    end else if (i == sif_pkg::IDX_GC16) begin
      r[7:0] = s.gcMc;
    end else if (i == sif_pkg::IDX_GC17) begin
      r[7:0] = s.gcVid;
    end else if (i == sif_pkg::IDX_GC18) begin
      r[7:0] = s.gcIpmc;
    end else if (i >= sif_pkg::IDX_PCTL0 && i < sif_pkg::IDX_PCTL0 + 8'h05) begin
      r[2:0] = s.portCtl[3'(i - sif_pkg::IDX_PCTL0)];
    end else if (i == sif_pkg::IDX_RSVD) begin
      r[31:0] = s.rsvdHi;
    end else if (i == sif_pkg::IDX_STAT) begin
      r[10:0] = {s.decAclHit, s.decAuth, s.decRule, s.decMap};
    end else if (i >= sif_pkg::IDX_MAC0 && i <= sif_pkg::IDX_MAC5) begin
      r[7:0] = s.ownMac[8 * (5 - 32'(i - sif_pkg::IDX_MAC0)) +: 8];
    end else begin
      r = 33'h0_0000_0000;
    end
    return r;
  endfunction

  always_comb begin
    nx       = st;
    rdRes    = regRd(st, s_axi_araddr[9:2]);
    wi       = st.awAddr[9:2];
    wrOld    = regRd(st, wi);
    wm       = merge(wrOld[31:0], st.wData, st.wStrb);
    ruleHit  = 16'h0000;
    aclHit   = 1'b0;
    best     = 4'h0;
    w0       = 32'h0000_0000;
    w1       = 32'h0000_0000;
    w2       = 32'h0000_0000;
    w3       = 32'h0000_0000;
    macK     = 48'h0000_0000_0000;
    ipK      = 32'h0000_0000;
    l4K      = 16'h0000;
    cmp      = 1'b0;
    pIdx     = (frmSrcPort > 3'h4) ? 3'h4 : frmSrcPort;
    srcBit   = portBit(pIdx);
    authMode = st.portCtl[pIdx][1:0];
    aclOn    = st.portCtl[pIdx][sif_pkg::ACL_EN];

    // per-entry match part: layer select, field select, equal or not-equal test
    for (int i = 0; i < sif_pkg::NRULE; i++) begin
      w0   = st.tbl[4*i];
      w1   = st.tbl[4*i+1];
      w2   = st.tbl[4*i+2];
      macK = w0[sif_pkg::W0_SD] ? frmSrcMac : frmDstMac;
      ipK  = w0[sif_pkg::W0_SD] ? frmIpSrc : frmIpDst;
      l4K  = w0[sif_pkg::W0_SD] ? frmL4Src : frmL4Dst;
      case (w0[1:0])
        sif_pkg::LAY_MAC: begin
          case (w0[3:2])
            2'h1:    cmp = frmEthType == w2[31:16];
            2'h2:    cmp = macK == {w2[15:0], w1};
            default: cmp = (frmEthType == w2[31:16]) && (macK == {w2[15:0], w1});
          endcase
        end
        sif_pkg::LAY_IP: begin
          case (w0[3:2])
            2'h1:    cmp = (ipK & w2) == (w1 & w2);
            2'h2:    cmp = frmIpSrc == frmIpDst;
            default: cmp = 1'b0;
          endcase
        end
        sif_pkg::LAY_L4: begin
          case (w0[3:2])
            2'h0:    cmp = frmIpProto == w1[7:0];
            2'h3:    cmp = frmL4Src == frmL4Dst;
            default: cmp = (l4K >= w1[15:0]) && (l4K <= w1[31:16]);
          endcase
        end
        default: cmp = 1'b0;
      endcase
      // a disabled entry never matches, whatever its compare sense
      ruleHit[i] = (w0[1:0] != sif_pkg::LAY_OFF) && (w0[sif_pkg::W0_EQ] ? cmp : !cmp);
    end

    // rule sets: AND of members, lowest leading index wins
    for (int j = 0; j < sif_pkg::NRULE; j++) begin
      w3 = st.tbl[4*j+3];
      if (w3[31:16] != 16'h0000 && (ruleHit & w3[31:16]) == w3[31:16]) begin
        if (!aclHit || w3[3:0] < best) begin
          best = w3[3:0];
        end
        aclHit = 1'b1;
      end
    end
    w0 = st.tbl[{best, 2'h0}];
    case (w0[7:6])
      2'h1:    aclMap = frmLookupMap | w0[12:8];
      2'h2:    aclMap = frmLookupMap & w0[12:8];
      2'h3:    aclMap = w0[12:8];
      default: aclMap = frmLookupMap;
    endcase

    // unknown-frame filters are one switch-wide setting
    if (frmVidMiss) begin
      baseMap = st.gcVid[sif_pkg::FILT_EN] ? st.gcVid[4:0] : sif_pkg::ALL_MAP;
    end else if (frmIpMcMiss) begin
      baseMap = st.gcIpmc[sif_pkg::FILT_EN] ? st.gcIpmc[4:0] : sif_pkg::ALL_MAP;
    end else if (frmMcMiss) begin
      baseMap = st.gcMc[sif_pkg::FILT_EN] ? st.gcMc[4:0] : sif_pkg::ALL_MAP;
    end else if (frmUniMiss) begin
      baseMap = st.gcUni[sif_pkg::FILT_EN] ? st.gcUni[4:0] : sif_pkg::ALL_MAP;
    end else begin
      baseMap = frmLookupMap;
    end
    baseMap = baseMap & ~srcBit;

    case (authMode)
      sif_pkg::AUTH_BLOCK: map = (aclOn && aclHit) ? aclMap : 5'h00;
      sif_pkg::AUTH_TRAP:  map = (aclOn && aclHit) ? aclMap : sif_pkg::CPU_MAP;
      default:             map = (aclOn && aclHit) ? aclMap : baseMap;
    endcase

    // auth frames reach the CPU in every mode, else a blocked port could never authenticate
    authHit = (frmDstMac == sif_pkg::AUTH_MAC) ||
              (frmDstMac == {st.rsvdHi, sif_pkg::AUTH_ALT_LO});
    if (authHit) begin
      map = sif_pkg::CPU_MAP;
    end
    selfHit = st.gcIpmc[sif_pkg::SELF_EN] && (frmSrcMac == st.ownMac);
    if (selfHit) begin
      map = 5'h00;
    end

    nx.decValid = frmValid;
    if (frmValid) begin
      nx.decMap    = map;
      nx.decAuth   = authHit;
      nx.decAclHit = aclOn && aclHit;
      nx.decRule   = best;
    end

    // write channel: address and data in either order, response after both
    if (s_axi_awvalid && st.awReady) begin
      nx.awAddr  = s_axi_awaddr;
      nx.awHeld  = 1'b1;
      nx.awReady = 1'b0;
    end
    if (s_axi_wvalid && st.wReady) begin
      nx.wData  = s_axi_wdata;
      nx.wStrb  = s_axi_wstrb;
      nx.wHeld  = 1'b1;
      nx.wReady = 1'b0;
    end
    if (st.awHeld && st.wHeld && !st.bValid) begin
      nx.awHeld = 1'b0;
      nx.wHeld  = 1'b0;
      nx.bValid = 1'b1;
      nx.bResp  = wrOld[32] ? sif_pkg::RESP_OKAY : sif_pkg::RESP_SLVERR;
      if (wi[7:6] == sif_pkg::TBL_SEL) begin
        nx.tbl[wi[5:0]] = wm;
      end else if (wi == sif_pkg::IDX_GC15) begin
        nx.gcUni = wm[7:0];
      end else if (wi == sif_pkg::IDX_GC16) begin
        nx.gcMc = wm[7:0];
      end else if (wi == sif_pkg::IDX_GC17) begin
        nx.gcVid = wm[7:0];
      end else if (wi == sif_pkg::IDX_GC18) begin
        nx.gcIpmc = wm[7:0];
      end else if (wi >= sif_pkg::IDX_PCTL0 && wi < sif_pkg::IDX_PCTL0 + 8'h05) begin
        nx.portCtl[3'(wi - sif_pkg::IDX_PCTL0)] = wm[2:0];
      end else if (wi == sif_pkg::IDX_RSVD) begin
        nx.rsvdHi = wm;
      end else if (wi >= sif_pkg::IDX_MAC0 && wi <= sif_pkg::IDX_MAC5) begin
        nx.ownMac[8 * (5 - 32'(wi - sif_pkg::IDX_MAC0)) +: 8] = wm[7:0];
      end
    end
    if (st.bValid && s_axi_bready) begin
      nx.bValid  = 1'b0;
      nx.awReady = 1'b1;
      nx.wReady  = 1'b1;
    end

    // read channel: one read in flight
    if (s_axi_arvalid && st.arReady) begin
      nx.rData   = rdRes[31:0];
      nx.rResp   = rdRes[32] ? sif_pkg::RESP_OKAY : sif_pkg::RESP_SLVERR;
      nx.rValid  = 1'b1;
      nx.arReady = 1'b0;
    end
    if (st.rValid && s_axi_rready) begin
      nx.rValid  = 1'b0;
      nx.arReady = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st           <= '0;
      st.awReady   <= 1'b1;
      st.wReady    <= 1'b1;
      st.arReady   <= 1'b1;
      st.gcUni     <= sif_pkg::GC_RST;
      st.gcMc      <= sif_pkg::GC_RST;
      st.gcVid     <= sif_pkg::GC_RST;
      st.gcIpmc    <= sif_pkg::GC_RST;
      st.portCtl   <= {sif_pkg::NPORT{sif_pkg::PCTL_RST}};
    end else if (ce) begin
      st <= nx;
    end
  end

  assign s_axi_awready = st.awReady;
  assign s_axi_wready  = st.wReady;
  assign s_axi_bvalid  = st.bValid;
  assign s_axi_bresp   = st.bResp;
  assign s_axi_arready = st.arReady;
  assign s_axi_rvalid  = st.rValid;
  assign s_axi_rdata   = st.rData;
  assign s_axi_rresp   = st.rResp;
  assign decValid      = st.decValid;
  assign decMap        = st.decMap;
  assign decAuth       = st.decAuth;
  assign decAclHit     = st.decAclHit;
  assign decRule       = st.decRule;

  logic noMiss;
  assign noMiss = !frmUniMiss && !frmMcMiss && !frmVidMiss && !frmIpMcMiss;

  self_drop_a:
    assert property (ce && frmValid && selfHit |=> decValid && decMap == 5'h00)
      else $error("self-sourced frame not dropped");
  auth_cpu_a:
    assert property (ce && frmValid && authHit && !selfHit |=> decAuth && decMap == 5'h10)
      else $error("auth frame not sent to cpu only");
  trap_cpu_a:
    assert property (ce && frmValid && authMode == 2'h3 && !aclOn && !selfHit
                     |=> decMap == 5'h10)
      else $error("trap port frame not redirected to cpu");
  block_drop_a:
    assert property (ce && frmValid && authMode == 2'h1 && !aclOn && !authHit
                     |=> decMap == 5'h00)
      else $error("blocked port frame forwarded");
  pass_fwd_a:
    assert property (ce && frmValid && authMode == 2'h0 && !aclOn && noMiss && !authHit
                     && !selfHit |=> decMap == ($past(frmLookupMap) & ~$past(srcBit)))
      else $error("pass port frame not forwarded by lookup map");
  uni_filter_a:
    assert property (ce && frmValid && frmUniMiss && !frmMcMiss && !frmVidMiss
                     && !frmIpMcMiss && authMode == 2'h0 && !aclOn && st.gcUni[5] && !authHit
                     |=> (decMap & ~$past(st.gcUni[4:0])) == 5'h00)
      else $error("unknown unicast left the filter map");
  flood_a:
    assert property (ce && frmValid && frmUniMiss && !frmMcMiss && !frmVidMiss
                     && !frmIpMcMiss && authMode == 2'h0 && !aclOn && !st.gcUni[5]
                     && !authHit && !selfHit |=> decMap == (5'h1F & ~$past(srcBit)))
      else $error("unknown unicast not flooded");
  port_ctl_a:
    assert property (ce && st.awHeld && st.wHeld && !st.bValid && st.wStrb[0]
                     && st.awAddr[9:2] == 8'h20
                     |=> s_axi_bvalid && st.portCtl[0] == $past(st.wData[2:0]))
      else $error("port control write not applied");
endmodule

// file: hdl/sif_pkg.sv
// Purpose: constants and state type for the ingress filter and port authentication block
// Assumes: word-wide register slots, byte address = index * 4
// Notes:   table entry = 4 words (control/action, key low, key high or mask, processing)
package sif_pkg;
  localparam int          NPORT       = 5;
  localparam int          NRULE       = 16;
  // register indices
  localparam logic [7:0]  IDX_GC15    = 8'h0F;
  localparam logic [7:0]  IDX_GC16    = 8'h10;
  localparam logic [7:0]  IDX_GC17    = 8'h11;
  localparam logic [7:0]  IDX_GC18    = 8'h12;
  localparam logic [7:0]  IDX_PCTL0   = 8'h20;
  localparam logic [7:0]  IDX_RSVD    = 8'h30;
  localparam logic [7:0]  IDX_STAT    = 8'h31;
  localparam logic [7:0]  IDX_MAC0    = 8'h68;
  localparam logic [7:0]  IDX_MAC5    = 8'h6D;
  localparam logic [1:0]  TBL_SEL     = 2'h2;
  // field positions
  localparam int          FILT_EN     = 5;
  localparam int          SELF_EN     = 6;
  localparam int          ACL_EN      = 2;
  localparam int          W0_SD       = 4;
  localparam int          W0_EQ       = 5;
  // reset values
  localparam logic [7:0]  GC_RST      = 8'h00;
  localparam logic [2:0]  PCTL_RST    = 3'h0;
  localparam logic [31:0] WORD_RST    = 32'h0000_0000;
  // encodings
  localparam logic [1:0]  AUTH_PASS   = 2'h0;
  localparam logic [1:0]  AUTH_BLOCK  = 2'h1;
  localparam logic [1:0]  AUTH_TRAP   = 2'h3;
  localparam logic [1:0]  LAY_OFF     = 2'h0;
  localparam logic [1:0]  LAY_MAC     = 2'h1;
  localparam logic [1:0]  LAY_IP      = 2'h2;
  localparam logic [1:0]  LAY_L4      = 2'h3;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [47:0] AUTH_MAC    = 48'h0180_C200_0003;
  localparam logic [15:0] AUTH_ALT_LO = 16'h0003;
  localparam logic [4:0]  CPU_MAP     = 5'h10;
  localparam logic [4:0]  ALL_MAP     = 5'h1F;

  typedef struct packed {
    logic              awReady;
    logic              wReady;
    logic              arReady;
    logic              bValid;
    logic              rValid;
    logic [1:0]        bResp;
    logic [1:0]        rResp;
    logic [31:0]       rData;
    logic              awHeld;
    logic              wHeld;
    logic [9:0]        awAddr;
    logic [31:0]       wData;
    logic [3:0]        wStrb;
    logic [7:0]        gcUni;
    logic [7:0]        gcMc;
    logic [7:0]        gcVid;
    logic [7:0]        gcIpmc;
    logic [47:0]       ownMac;
    logic [4:0][2:0]   portCtl;
    logic [31:0]       rsvdHi;
    logic [63:0][31:0] tbl;
    logic              decValid;
    logic [4:0]        decMap;
    logic              decAuth;
    logic              decAclHit;
    logic [3:0]        decRule;
  } sif_state_t;
endpackage

// file: testbench/sif_lookup_model.sv
// Purpose: lookup engine stand-in that hands frame descriptors to the filter
// Assumes: one descriptor per call, launched right after a rising edge
// Notes:   MACs, lookup map and miss flags are inverted once the strobe drops so stale values never pass as fresh
`timescale 1ns/10ps
module sif_lookup_model (
  // clock
  input  wire logic   core_clk,
  // descriptor
  output logic        frmValid,
  output logic [2:0]  frmSrcPort,
  output logic [47:0] frmDstMac,
  output logic [47:0] frmSrcMac,
  output logic [15:0] frmEthType,
  output logic [31:0] frmIpSrc,
  output logic [31:0] frmIpDst,
  output logic [7:0]  frmIpProto,
  output logic [15:0] frmL4Src,
  output logic [15:0] frmL4Dst,
  output logic [4:0]  frmLookupMap,
  output logic        frmUniMiss,
  output logic        frmMcMiss,
  output logic        frmVidMiss,
  output logic        frmIpMcMiss
);
  initial begin
    frmValid = 1'b0;
    frmSrcPort = 3'h0;
    frmDstMac = 48'h0000_0000_0000;
    frmSrcMac = 48'h0000_0000_0000;
    frmEthType = 16'h0800;
    frmIpSrc = 32'h0A00_0001;
    frmIpDst = 32'h0A00_0002;
    frmIpProto = 8'h06;
    frmL4Src = 16'h1F90;
    frmL4Dst = 16'h0050;
    frmLookupMap = 5'h00;
    {frmIpMcMiss, frmVidMiss, frmMcMiss, frmUniMiss} = 4'h0;
  end

  // lookup map stands for what software programmed, reserved multicast included
  task automatic send(input logic [2:0] port, input logic [47:0] dst, input logic [47:0] src,
                      input logic [4:0] map, input logic [3:0] miss);
    @(posedge core_clk);
    frmValid <= 1'b1;
    frmSrcPort <= port;
    frmDstMac <= dst;
    frmSrcMac <= src;
    frmLookupMap <= map;
    {frmIpMcMiss, frmVidMiss, frmMcMiss, frmUniMiss} <= miss;
    @(posedge core_clk);
    frmValid <= 1'b0;
    frmDstMac <= ~dst;
    frmSrcMac <= ~src;
    frmLookupMap <= ~map;
    {frmIpMcMiss, frmVidMiss, frmMcMiss, frmUniMiss} <= ~miss;
  endtask
endmodule

// file: testbench/sif_filter_bench.sv
// Purpose: self-checking bench for the ingress filter and port authentication block
// Assumes: register bus answers in its own time, decision one cycle after a descriptor
// Notes:   clock enable is held high; freezing is not exercised
`timescale 1ns/10ps
module sif_filter_bench;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        s_axi_awvalid = 1'b0;
  logic [9:0]  s_axi_awaddr = 10'h000;
  logic        s_axi_wvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic [9:0]  s_axi_araddr = 10'h000;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, frmIpSrc, frmIpDst;
  logic        frmValid, frmUniMiss, frmMcMiss, frmVidMiss, frmIpMcMiss;
  logic [2:0]  frmSrcPort;
  logic [47:0] frmDstMac, frmSrcMac;
  logic [15:0] frmEthType, frmL4Src, frmL4Dst;
  logic [7:0]  frmIpProto;
  logic [4:0]  frmLookupMap, decMap;
  logic        decValid, decAuth, decAclHit;
  logic [3:0]  decRule;
  int          failures = 0;
  int          checked = 0;
  logic [4:0]  maps [4] = '{5'h0E, 5'h0C, 5'h1A, 5'h16};
  logic [7:0]  fidx [4] = '{sif_pkg::IDX_GC15, sif_pkg::IDX_GC16, sif_pkg::IDX_GC17,
                            sif_pkg::IDX_GC18};
  logic [1:0]  modes [3] = '{sif_pkg::AUTH_PASS, sif_pkg::AUTH_BLOCK, sif_pkg::AUTH_TRAP};
  logic [4:0]  mexp [3] = '{5'h17, 5'h00, sif_pkg::CPU_MAP};
  logic [31:0] ent0 [4] = '{32'h0000_06E9, 32'hBB00_1234, 32'h0000_00AA, 32'h0001_0000};
  logic [31:0] ent3 [4] = '{32'h0000_08E9, 32'hBB00_1234, 32'h0000_00AA, 32'h0008_0003};
  // entry 1: masked IP dst, AND map; entry 2: L4 dst port range, OR map
  logic [31:0] ent1 [4] = '{32'h0000_06A6, 32'h0A00_0002, 32'hFFFF_FFFF, 32'h0002_0001};
  logic [31:0] ent2 [4] = '{32'h0000_0867, 32'h0050_0050, 32'h0000_0000, 32'h0004_0002};
  logic [47:0] own = 48'h0A1B_2C3D_4E5F;
  logic [47:0] hitDst = 48'h00AA_BB00_1234;
  logic [47:0] plain = 48'h0000_1111_2222;

  always #5 core_clk = ~core_clk;

  sif_filter sif_filter_i (
    .core_clk(core_clk), .rst_n(rst_n), .ce(1'b1),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .frmValid(frmValid),
    .frmSrcPort(frmSrcPort), .frmDstMac(frmDstMac), .frmSrcMac(frmSrcMac),
    .frmEthType(frmEthType), .frmIpSrc(frmIpSrc), .frmIpDst(frmIpDst),
    .frmIpProto(frmIpProto), .frmL4Src(frmL4Src), .frmL4Dst(frmL4Dst),
    .frmLookupMap(frmLookupMap), .frmUniMiss(frmUniMiss), .frmMcMiss(frmMcMiss),
    .frmVidMiss(frmVidMiss), .frmIpMcMiss(frmIpMcMiss), .decValid(decValid),
    .decMap(decMap), .decAuth(decAuth), .decAclHit(decAclHit), .decRule(decRule)
  );

  sif_lookup_model sif_lookup_model_i (
    .core_clk(core_clk), .frmValid(frmValid), .frmSrcPort(frmSrcPort),
    .frmDstMac(frmDstMac), .frmSrcMac(frmSrcMac), .frmEthType(frmEthType),
    .frmIpSrc(frmIpSrc), .frmIpDst(frmIpDst), .frmIpProto(frmIpProto),
    .frmL4Src(frmL4Src), .frmL4Dst(frmL4Dst), .frmLookupMap(frmLookupMap),
    .frmUniMiss(frmUniMiss), .frmMcMiss(frmMcMiss), .frmVidMiss(frmVidMiss),
    .frmIpMcMiss(frmIpMcMiss)
  );

  task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // outputs are registered, so values read right after an edge are the ones it sampled
  task automatic axw(input logic [7:0] idx, input logic [31:0] dat, input logic [1:0] eresp);
    @(posedge core_clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= dat;
    s_axi_wstrb <= 4'hF;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid === 1'b1));
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, eresp);
  endtask

  task automatic axr(input logic [7:0] idx, input logic [31:0] edat, input logic [1:0] eresp);
    @(posedge core_clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= {idx, 2'b00};
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid === 1'b1));
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, edat);
    chk("rresp", s_axi_rresp, eresp);
  endtask

  task automatic frame(input logic [2:0] port, input logic [47:0] dst, input logic [47:0] src,
                       input logic [4:0] map, input logic [3:0] miss, input logic [4:0] emap);
    sif_lookup_model_i.send(port, dst, src, map, miss);
    #1;
    chk("decValid", decValid, 1'b1);
    chk("decMap", decMap, emap);
  endtask

  task automatic test_done();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #300000;
    failures++;
    test_done();
  end

  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    axr(sif_pkg::IDX_PCTL0, 32'h0000_0000, sif_pkg::RESP_OKAY);
    axr(8'h40, 32'h0000_0000, sif_pkg::RESP_SLVERR);
    axw(8'h40, 32'h0000_0001, sif_pkg::RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      axw(fidx[i], 32'h0000_0020 | maps[i], sif_pkg::RESP_OKAY);
      axr(fidx[i], 32'h0000_0020 | maps[i], sif_pkg::RESP_OKAY);
      frame(3'h0, plain, own, 5'h1F, 4'h1 << i, maps[i]);
      frame(3'h2, plain, own, 5'h1F, 4'h1 << i, maps[i] & 5'h1B);
      axw(fidx[i], 32'h0000_0000, sif_pkg::RESP_OKAY);
    end
    frame(3'h1, plain, own, 5'h04, 4'h1, 5'h1D);
    for (int b = 0; b < 6; b++) begin
      axw(sif_pkg::IDX_MAC0 + 8'(b), {24'h00_0000, own[47-8*b -: 8]}, sif_pkg::RESP_OKAY);
    end
    axr(8'h6B, 32'h0000_003D, sif_pkg::RESP_OKAY);
    axw(sif_pkg::IDX_GC18, 32'h0000_0040, sif_pkg::RESP_OKAY);
    frame(3'h0, plain, own, 5'h1E, 4'h0, 5'h00);
    frame(3'h0, plain, 48'h0A1B_2C3D_4E50, 5'h1E, 4'h0, 5'h1E);
    axw(sif_pkg::IDX_GC18, 32'h0000_0000, sif_pkg::RESP_OKAY);
    frame(3'h1, sif_pkg::AUTH_MAC, plain, 5'h1F, 4'h0, sif_pkg::CPU_MAP);
    chk("decAuth", decAuth, 1'b1);
    axw(sif_pkg::IDX_RSVD, 32'h0180_C2AB, sif_pkg::RESP_OKAY);
    frame(3'h1, 48'h0180_C2AB_0003, plain, 5'h1F, 4'h0, sif_pkg::CPU_MAP);
    for (int m = 0; m < 3; m++) begin
      axw(sif_pkg::IDX_PCTL0 + 8'h03, {30'h0000_0000, modes[m]}, sif_pkg::RESP_OKAY);
      frame(3'h3, plain, own, 5'h17, 4'h0, mexp[m]);
    end
    // software admits the port once authenticated
    axw(sif_pkg::IDX_PCTL0 + 8'h03, 32'h0000_0000, sif_pkg::RESP_OKAY);
    frame(3'h3, plain, own, 5'h17, 4'h0, 5'h17);
    for (int k = 0; k < 4; k++) begin
      axw(8'h80 + 8'(k), ent0[k], sif_pkg::RESP_OKAY);
      axw(8'h8C + 8'(k), ent3[k], sif_pkg::RESP_OKAY);
    end
    axw(sif_pkg::IDX_PCTL0 + 8'h03, 32'h0000_0005, sif_pkg::RESP_OKAY);
    frame(3'h3, hitDst, own, 5'h17, 4'h0, 5'h06);
    chk("decAclHit", decAclHit, 1'b1);
    chk("decRule", decRule, 4'h0);
    frame(3'h3, plain, own, 5'h17, 4'h0, 5'h00);
    axw(sif_pkg::IDX_PCTL0 + 8'h03, 32'h0000_0007, sif_pkg::RESP_OKAY);
    frame(3'h3, plain, own, 5'h17, 4'h0, sif_pkg::CPU_MAP);
    frame(3'h3, hitDst, own, 5'h17, 4'h0, 5'h06);
    axw(sif_pkg::IDX_PCTL0 + 8'h03, 32'h0000_0004, sif_pkg::RESP_OKAY);
    frame(3'h3, plain, own, 5'h17, 4'h0, 5'h17);
    frame(3'h3, hitDst, own, 5'h17, 4'h0, 5'h06);
    // switching entry 0 off leaves entry 3 as the only matching set
    axw(8'h80, 32'h0000_06E8, sif_pkg::RESP_OKAY);
    frame(3'h3, hitDst, own, 5'h17, 4'h0, 5'h08);
    chk("decRule", decRule, 4'h3);
    for (int k = 0; k < 4; k++) begin
      axw(8'h88 + 8'(k), ent2[k], sif_pkg::RESP_OKAY);
    end
    frame(3'h3, plain, own, 5'h17, 4'h0, 5'h1F);
    chk("decRule", decRule, 4'h2);
    for (int k = 0; k < 4; k++) begin
      axw(8'h84 + 8'(k), ent1[k], sif_pkg::RESP_OKAY);
    end
    frame(3'h3, plain, own, 5'h17, 4'h0, 5'h06);
    chk("decRule", decRule, 4'h1);
    // narrow register keeps only its three low bits
    axw(sif_pkg::IDX_PCTL0, 32'hFFFF_FFFF, sif_pkg::RESP_OKAY);
    axr(sif_pkg::IDX_PCTL0, 32'h0000_0007, sif_pkg::RESP_OKAY);
    test_done();
  end
endmodule
